// *** shared/ptu_pkg.sv ***
package ptu_pkg;

    // Register indices; the byte address on the port is four times the index
    localparam logic [5:0] IDX_MODE = 6'h2A;
    localparam logic [5:0] IDX_PRE_LO = 6'h2B;
    localparam logic [5:0] IDX_RLD_HI = 6'h2C;
    localparam logic [5:0] IDX_RLD_LO = 6'h2D;
    localparam logic [5:0] IDX_CNT_HI = 6'h2E;
    localparam logic [5:0] IDX_CNT_LO = 6'h2F;
    localparam logic [5:0] IDX_CTRL = 6'h0C;
    localparam logic [5:0] IDX_STAT = 6'h0D;
    localparam logic [5:0] IDX_IRQ_ST = 6'h0E;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h0F;
    localparam logic [5:0] IDX_CFG = 6'h10;

    // Reset values
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_CFG = 2'h0;
    localparam logic [1:0] RST_IRQ = 2'h0;

    // Field positions in the control and interrupt registers
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int IRQ_ZERO_BIT = 0;
    localparam int IRQ_RXSTOP_BIT = 1;

    // Gate source codes
    localparam logic [1:0] GATE_NONE = 2'h0;
    localparam logic [1:0] GATE_MUX = 2'h1;
    localparam logic [1:0] GATE_AUX = 2'h2;

    // Received bits that end the protocol-driven count (start bit plus four)
    localparam logic [2:0] RX_STOP_BITS = 3'h5;

    // Timer mode register layout, bit 7 down to bit 0
    typedef struct packed {
        logic protocol_start_en;
        logic [1:0] gate_select;
        logic auto_reload_en;
        logic [3:0] prescale_upper;
    } ptu_mode_t;

    // Loose configuration bits gathered in one register
    typedef struct packed {
        logic multi_receive_mode;
        logic even_divide_sel;
    } ptu_cfg_t;

endpackage

// *** hw/ptu_timer.sv ***
`timescale 1ns/1ps
module ptu_timer #(
    parameter int CNT_W = 16,
    parameter int PRE_W = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [7:0] rd_data_o,
    input wire logic ref_tick_i,
    input wire logic tx_end_i,
    input wire logic rx_bit_i,
    input wire logic mux_input_pin_i,
    input wire logic aux_pin_one_i,
    output logic count_active_o,
    output logic irq_o
);

    // Register split into bytes fixes both widths
    if (CNT_W != 16 || PRE_W != 12)
    begin : g_check
        $error("ptu_timer supports only CNT_W 16 and PRE_W 12");
    end

    ptu_pkg::ptu_mode_t mode_q, mode_d;
    ptu_pkg::ptu_cfg_t cfg_q, cfg_d;
    logic [7:0] pre_lo_q, pre_lo_d;
    logic [7:0] rld_hi_q, rld_hi_d;
    logic [7:0] rld_lo_q, rld_lo_d;
    logic [1:0] irq_st_q, irq_st_d;
    logic [1:0] irq_mask_q, irq_mask_d;
    logic [7:0] rd_data_q, rd_data_d;
    logic irq_q, irq_d;
    logic act_q, act_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [PRE_W:0] pre_q, pre_d;
    logic [2:0] rxb_q, rxb_d;
    logic run_q, run_d;

    logic [5:0] idx;
    logic bus_ok;
    logic wr_hit_ctrl;
    logic sw_start;
    logic stop_req;
    logic start_ev;
    logic gate_open;
    logic rx_stop_en;
    logic [PRE_W:0] pre_last;
    logic [CNT_W-1:0] reload;
    logic tick;
    logic zero_ev;
    logic rxstop_ev;

    // Word-aligned byte addresses only; low address bits must be zero
    assign idx = addr_i[7:2];
    assign bus_ok = (addr_i[1:0] == 2'h0);
    assign wr_hit_ctrl = wr_en_i && bus_ok && (idx == ptu_pkg::IDX_CTRL);
    assign sw_start = wr_hit_ctrl && wr_data_i[ptu_pkg::CTRL_START_BIT];
    assign stop_req = wr_hit_ctrl && wr_data_i[ptu_pkg::CTRL_STOP_BIT];

    // Start comes from the protocol only when enabled, or from software
    assign start_ev = (mode_q.protocol_start_en && tx_end_i) || sw_start;
    assign rx_stop_en = mode_q.protocol_start_en && !cfg_q.multi_receive_mode;
    assign reload = {rld_hi_q, rld_lo_q};

    // Code 11 is treated as a closed gate so the timer cannot run uncontrolled
    always_comb
    begin
        case (mode_q.gate_select)
            ptu_pkg::GATE_NONE: gate_open = 1'b1;
            ptu_pkg::GATE_MUX: gate_open = mux_input_pin_i;
            ptu_pkg::GATE_AUX: gate_open = aux_pin_one_i;
            default: gate_open = 1'b0;
        endcase
    end

    // Division minus one is {P, even}: 2P+1 or 2P+2 ticks of the reference
    assign pre_last = {mode_q.prescale_upper, pre_lo_q, cfg_q.even_divide_sel};
    assign tick = run_q && gate_open && ref_tick_i && (pre_q == pre_last);

    // Register file next values; writes to the reload bytes never touch cnt_q
    always_comb
    begin
        mode_d = mode_q;
        cfg_d = cfg_q;
        pre_lo_d = pre_lo_q;
        rld_hi_d = rld_hi_q;
        rld_lo_d = rld_lo_q;
        irq_mask_d = irq_mask_q;
        irq_st_d = irq_st_q;
        if (wr_en_i && bus_ok)
        begin
            case (idx)
                ptu_pkg::IDX_MODE: mode_d = wr_data_i;
                ptu_pkg::IDX_PRE_LO: pre_lo_d = wr_data_i;
                ptu_pkg::IDX_RLD_HI: rld_hi_d = wr_data_i;
                ptu_pkg::IDX_RLD_LO: rld_lo_d = wr_data_i;
                ptu_pkg::IDX_CFG: cfg_d = wr_data_i[1:0];
                ptu_pkg::IDX_IRQ_MASK: irq_mask_d = wr_data_i[1:0];
                ptu_pkg::IDX_IRQ_ST: irq_st_d = irq_st_q & ~wr_data_i[1:0];
                default: ;
            endcase
        end
        // Set after clear, so an event in the clearing cycle survives
        if (zero_ev)
        begin
            irq_st_d[ptu_pkg::IRQ_ZERO_BIT] = 1'b1;
        end
        if (rxstop_ev)
        begin
            irq_st_d[ptu_pkg::IRQ_RXSTOP_BIT] = 1'b1;
        end
    end

    // Read mux; unmapped or misaligned addresses read as zero
    always_comb
    begin
        rd_data_d = 8'h00;
        if (rd_en_i && bus_ok)
        begin
            case (idx)
                ptu_pkg::IDX_MODE: rd_data_d = mode_q;
                ptu_pkg::IDX_PRE_LO: rd_data_d = pre_lo_q;
                ptu_pkg::IDX_RLD_HI: rd_data_d = rld_hi_q;
                ptu_pkg::IDX_RLD_LO: rd_data_d = rld_lo_q;
                ptu_pkg::IDX_CNT_HI: rd_data_d = cnt_q[15:8];
                ptu_pkg::IDX_CNT_LO: rd_data_d = cnt_q[7:0];
                ptu_pkg::IDX_STAT: rd_data_d = {7'h00, act_q};
                ptu_pkg::IDX_IRQ_ST: rd_data_d = {6'h00, irq_st_q};
                ptu_pkg::IDX_IRQ_MASK: rd_data_d = {6'h00, irq_mask_q};
                ptu_pkg::IDX_CFG: rd_data_d = {6'h00, cfg_q};
                default: rd_data_d = 8'h00;
            endcase
        end
    end

    // Timer core: stop beats start, start beats counting
    always_comb
    begin
        cnt_d = cnt_q;
        run_d = run_q;
        pre_d = pre_q;
        rxb_d = rxb_q;
        zero_ev = 1'b0;
        rxstop_ev = 1'b0;
        if (stop_req)
        begin
            run_d = 1'b0;
        end
        else if (start_ev)
        begin
            cnt_d = reload;
            run_d = 1'b1;
            pre_d = '0;
            rxb_d = 3'h0;
        end
        else if (run_q)
        begin
            // Prescaler only advances while the gate is open
            if (gate_open && ref_tick_i)
            begin
                if (tick)
                begin
                    pre_d = '0;
                    if (cnt_q == '0)
                    begin
                        zero_ev = 1'b1;
                        if (mode_q.auto_reload_en)
                        begin
                            cnt_d = reload;
                        end
                        else
                        begin
                            run_d = 1'b0;
                        end
                    end
                    else
                    begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end
                else
                begin
                    pre_d = pre_q + 1'b1;
                end
            end
            // Reception stops the count in single-reception protocol mode
            if (rx_stop_en && rx_bit_i)
            begin
                rxb_d = rxb_q + 3'h1;
                if (rxb_q == ptu_pkg::RX_STOP_BITS - 3'h1)
                begin
                    run_d = 1'b0;
                    rxstop_ev = 1'b1;
                end
            end
        end
    end

    // Status and interrupt outputs are registered copies
    assign act_d = run_q && gate_open;
    assign irq_d = |(irq_st_q & irq_mask_q);

    // State registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_q <= ptu_pkg::RST_MODE;
            cfg_q <= ptu_pkg::RST_CFG;
            pre_lo_q <= ptu_pkg::RST_BYTE;
            rld_hi_q <= ptu_pkg::RST_BYTE;
            rld_lo_q <= ptu_pkg::RST_BYTE;
            irq_st_q <= ptu_pkg::RST_IRQ;
            irq_mask_q <= ptu_pkg::RST_IRQ;
            rd_data_q <= 8'h00;
            irq_q <= 1'b0;
            act_q <= 1'b0;
            cnt_q <= '0;
            pre_q <= '0;
            rxb_q <= 3'h0;
            run_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            cfg_q <= cfg_d;
            pre_lo_q <= pre_lo_d;
            rld_hi_q <= rld_hi_d;
            rld_lo_q <= rld_lo_d;
            irq_st_q <= irq_st_d;
            irq_mask_q <= irq_mask_d;
            rd_data_q <= rd_data_d;
            irq_q <= irq_d;
            act_q <= act_d;
            cnt_q <= cnt_d;
            pre_q <= pre_d;
            rxb_q <= rxb_d;
            run_q <= run_d;
        end
    end

    assign rd_data_o = rd_data_q;
    assign irq_o = irq_q;
    assign count_active_o = act_q;

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_proto_start;
        mode_q.protocol_start_en && tx_end_i && !stop_req;
    endsequence

    sequence s_loaded;
        run_q && (cnt_q == $past(reload));
    endsequence

    chk_tx_start: assert property (s_proto_start |=> s_loaded)
        else $error("protocol start did not load and run the timer");

    chk_fifth_bit: assert property (run_q && rx_stop_en && rx_bit_i && rxb_q == 3'h4 && !start_ev
        && !stop_req |=> !run_q ##1 !count_active_o)
        else $error("timer kept running after the fifth received bit");

    chk_multi_rx: assert property (run_q && mode_q.protocol_start_en && cfg_q.multi_receive_mode
        && rx_bit_i && !stop_req && !tick |=> run_q)
        else $error("reception stopped the timer in multiple reception mode");

    chk_no_proto: assert property (!run_q && !mode_q.protocol_start_en && tx_end_i && !sw_start
        |=> !run_q)
        else $error("transmission end started timer with protocol start off");

    chk_gate_hold: assert property (run_q && !gate_open && !start_ev && !stop_req
        |=> $stable(cnt_q) && $stable(pre_q))
        else $error("counter moved while the gate was closed");

    chk_active_gate: assert property (run_q && gate_open && !stop_req && !start_ev
        ##1 run_q && gate_open |=> count_active_o)
        else $error("count_active low while gate enables the running timer");

    chk_auto_reload: assert property (tick && cnt_q == '0 && mode_q.auto_reload_en && !stop_req
        && !start_ev && !(rx_stop_en && rx_bit_i) |=> run_q && cnt_q == $past(reload))
        else $error("auto reload did not restart from the reload value");

    chk_zero_irq: assert property (tick && cnt_q == '0 && !mode_q.auto_reload_en && !stop_req
        && !start_ev |=> !run_q && irq_st_q[ptu_pkg::IRQ_ZERO_BIT])
        else $error("reaching zero did not stop and flag");

    chk_prescale: assert property (run_q && gate_open && ref_tick_i && !start_ev && !stop_req
        |=> pre_q == (($past(pre_q) == $past(pre_last)) ? '0 : $past(pre_q) + 1'b1))
        else $error("prescaler step wrong");

    chk_reload_write: assert property (run_q && wr_en_i && (idx == ptu_pkg::IDX_RLD_HI
        || idx == ptu_pkg::IDX_RLD_LO) && !tick && !start_ev |=> $stable(cnt_q))
        else $error("reload write disturbed the running count");

    chk_decrement: assert property (tick && cnt_q != '0 && !stop_req && !start_ev
        |=> cnt_q == $past(cnt_q) - 1'b1)
        else $error("counter did not decrement on a tick");

    chk_stop_now: assert property (stop_req |=> !run_q && $stable(cnt_q) ##1 !count_active_o)
        else $error("stop_now did not halt the timer");

endmodule

// *** sim/ptu_timer_tb_top.sv ***
`timescale 1ns/1ps
module ptu_timer_tb_top;
    // Byte addresses on the register port are four times the index
    localparam logic [7:0] a_mode = {ptu_pkg::IDX_MODE, 2'h0};
    localparam logic [7:0] a_pre = {ptu_pkg::IDX_PRE_LO, 2'h0};
    localparam logic [7:0] a_rh = {ptu_pkg::IDX_RLD_HI, 2'h0};
    localparam logic [7:0] a_rl = {ptu_pkg::IDX_RLD_LO, 2'h0};
    localparam logic [7:0] a_ch = {ptu_pkg::IDX_CNT_HI, 2'h0};
    localparam logic [7:0] a_cl = {ptu_pkg::IDX_CNT_LO, 2'h0};
    localparam logic [7:0] a_ctrl = {ptu_pkg::IDX_CTRL, 2'h0};
    localparam logic [7:0] a_ist = {ptu_pkg::IDX_IRQ_ST, 2'h0};
    localparam logic [7:0] a_msk = {ptu_pkg::IDX_IRQ_MASK, 2'h0};
    localparam logic [7:0] a_cfg = {ptu_pkg::IDX_CFG, 2'h0};
    localparam logic [7:0] a_st = {ptu_pkg::IDX_STAT, 2'h0};
    logic clk_i;
    logic rst_i;
    logic [7:0] addr_i;
    logic [7:0] wr_data_i;
    logic wr_en_i;
    logic rd_en_i;
    logic [7:0] rd_data_o;
    logic ref_tick_i;
    logic tx_end_i;
    logic rx_bit_i;
    logic mux_input_pin_i;
    logic aux_pin_one_i;
    logic count_active_o;
    logic irq_o;
    int failures;
    int n_compared;
    int cycles;
    int len;
    logic [7:0] rd_q;
    logic [7:0] first_q;
    // Divider cases: reload, twelve-bit prescaler, even select
    logic [15:0] c_rld [5] = '{16'h0005, 16'h0003, 16'h0002, 16'h0000, 16'h0001};
    logic [11:0] c_pre [5] = '{12'h000, 12'h001, 12'h001, 12'h101, 12'h0FF};
    logic c_even [5] = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h1};
    logic [7:0] rst_addr [6] = '{a_mode, a_pre, a_rh, a_rl, a_cfg, a_msk};

    ptu_timer dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .ref_tick_i(ref_tick_i),
        .tx_end_i(tx_end_i), .rx_bit_i(rx_bit_i), .mux_input_pin_i(mux_input_pin_i),
        .aux_pin_one_i(aux_pin_one_i), .count_active_o(count_active_o), .irq_o(irq_o));

    // Bench clock, 100 ns period
    initial
    begin
        clk_i = 1'h0;
        forever #50 clk_i = ~clk_i;
    end

    // Longest planned run is 1024 cycles, so a hang is cut well above it
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Strobes rise after one edge and fall after the next, so each lasts one cycle
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        wr_en_i <= 1'h1;
        addr_i <= addr;
        wr_data_i <= data;
        @(posedge clk_i);
        wr_en_i <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe; sampled mid-cycle
    task automatic rd(input logic [7:0] addr);
        @(posedge clk_i);
        rd_en_i <= 1'h1;
        addr_i <= addr;
        @(posedge clk_i);
        rd_en_i <= 1'h0;
        @(negedge clk_i);
        rd_q = rd_data_o;
    endtask

    task automatic rc(input logic [7:0] addr, input logic [7:0] exp, input string what);
        rd(addr);
        chk(what, {8'h00, rd_q}, {8'h00, exp});
    endtask

    task automatic setup(input logic [7:0] mode, input logic [7:0] pre, input logic [7:0] cfg,
        input logic [15:0] rld);
        wr(a_mode, mode);
        wr(a_pre, pre);
        wr(a_cfg, cfg);
        wr(a_rh, rld[15:8]);
        wr(a_rl, rld[7:0]);
    endtask

    // One-cycle pulses with a gap, on the transmit-end or the receive-bit line
    task automatic pulse(input logic tx, input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            tx_end_i <= tx;
            rx_bit_i <= ~tx;
            @(posedge clk_i);
            tx_end_i <= 1'h0;
            rx_bit_i <= 1'h0;
        end
    endtask

    // Both outputs are registered levels, so a few cycles settle them first
    task automatic st(input logic act_e, input logic irq_e);
        repeat (3) @(negedge clk_i);
        chk("count active", {15'h0000, count_active_o}, {15'h0000, act_e});
        chk("irq level", {15'h0000, irq_o}, {15'h0000, irq_e});
    endtask

    // Length of the active window equals the running time, both ends lag alike
    task automatic measure(output int n);
        int guard;
        guard = 0;
        n = 0;
        while (count_active_o !== 1'h1 && guard < 20)
        begin
            @(negedge clk_i);
            guard++;
        end
        while (count_active_o === 1'h1 && n < 5000)
        begin
            @(negedge clk_i);
            n++;
        end
    endtask

    // Main sequence
    initial
    begin
        rst_i = 1'h1;
        addr_i = 8'h00;
        wr_data_i = 8'h00;
        wr_en_i = 1'h0;
        rd_en_i = 1'h0;
        ref_tick_i = 1'h1;
        tx_end_i = 1'h0;
        rx_bit_i = 1'h0;
        mux_input_pin_i = 1'h0;
        aux_pin_one_i = 1'h0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        foreach (rst_addr[i])
            rc(rst_addr[i], 8'h00, "reset value");
        rc(8'hA9, 8'h00, "misaligned read");
        rc({6'h20, 2'h0}, 8'h00, "unmapped read");
        wr(a_ch, 8'hFF);
        rc(a_ch, 8'h00, "count upper");
        rc(a_cl, 8'h00, "count lower");
        wr(a_rh, 8'hA5);
        rc(a_rh, 8'hA5, "reload upper");
        // Five tick rates and the upper prescaler nibble, ending in the zero flag
        for (int i = 0; i < 5; i++)
        begin
            setup({4'h0, c_pre[i][11:8]}, c_pre[i][7:0], {7'h00, c_even[i]}, c_rld[i]);
            wr(a_ctrl, 8'h01);
            measure(len);
            chk("run length", 16'(len), 16'((c_rld[i] + 1) * (2 * c_pre[i] + 1 + c_even[i])));
            rc(a_ist, 8'h01, "zero flag");
            wr(a_ist, 8'h01);
        end
        // Reload rewritten mid-run; stop freezes the count
        setup(8'h00, 8'h00, 8'h00, 16'h0010);
        wr(a_ctrl, 8'h01);
        wr(a_rl, 8'h02);
        wr(a_ctrl, 8'h02);
        rd(a_cl);
        first_q = rd_q;
        chk("count kept", 16'(first_q > 8'h08), 16'h0001);
        rc(a_cl, first_q, "count held");
        st(1'h0, 1'h0);
        wr(a_ctrl, 8'h01);
        measure(len);
        chk("new reload length", 16'(len), 16'h0003);
        wr(a_ist, 8'h01);
        // Protocol events ignored, then start on transmit end and stop on receive
        setup(8'h00, 8'h00, 8'h00, 16'h0100);
        pulse(1'h1, 1);
        st(1'h0, 1'h0);
        wr(a_ctrl, 8'h01);
        pulse(1'h0, 6);
        st(1'h1, 1'h0);
        wr(a_ctrl, 8'h02);
        wr(a_mode, 8'h80);
        pulse(1'h1, 1);
        st(1'h1, 1'h0);
        pulse(1'h0, 4);
        st(1'h1, 1'h0);
        pulse(1'h0, 1);
        st(1'h0, 1'h0);
        rc(a_ist, 8'h02, "receive stop flag");
        wr(a_ist, 8'h03);
        wr(a_cfg, 8'h02);
        pulse(1'h1, 1);
        pulse(1'h0, 6);
        st(1'h1, 1'h0);
        wr(a_ctrl, 8'h02);
        st(1'h0, 1'h0);
        // Gate sources: mux pin, aux pin, unused code
        setup(8'h20, 8'h00, 8'h00, 16'h0100);
        wr(a_ctrl, 8'h01);
        st(1'h0, 1'h0);
        rc(a_ch, 8'h01, "count held by gate");
        @(posedge clk_i);
        mux_input_pin_i <= 1'h1;
        st(1'h1, 1'h0);
        rc(a_st, 8'h01, "status running");
        wr(a_mode, 8'h40);
        st(1'h0, 1'h0);
        @(posedge clk_i);
        aux_pin_one_i <= 1'h1;
        st(1'h1, 1'h0);
        wr(a_mode, 8'h60);
        st(1'h0, 1'h0);
        wr(a_ctrl, 8'h02);
        // Auto reload keeps running; interrupt masked, unmasked and cleared
        setup(8'h10, 8'h00, 8'h00, 16'h0002);
        wr(a_msk, 8'h01);
        wr(a_ctrl, 8'h01);
        repeat (20) @(negedge clk_i);
        st(1'h1, 1'h1);
        wr(a_ctrl, 8'h02);
        wr(a_msk, 8'h00);
        st(1'h0, 1'h0);
        wr(a_msk, 8'h01);
        st(1'h0, 1'h1);
        wr(a_ist, 8'h01);
        st(1'h0, 1'h0);
        // Without reference ticks the prescaler never fires, so the count must hold
        @(posedge clk_i);
        ref_tick_i <= 1'h0;
        wr(a_ctrl, 8'h01);
        repeat (4) @(posedge clk_i);
        rc(a_cl, 8'h02, "count held without reference");
        wr(a_ctrl, 8'h02);
        end_of_test();
    end
endmodule
